// ==== src/lnbocf_regs.vh ====
/*
  register offsets, field positions, reset values and timing figures
  for the overcurrent fault control block.
  assumes inclusion by bare name from the block's design file.
*/
`ifndef LNBOCF_REGS_VH
`define LNBOCF_REGS_VH

// ==========================================================
// register byte offsets
`define LNBOCF_CTRL_OFS     12'h000
`define LNBOCF_STAT_OFS     12'h004
`define LNBOCF_IRQ_OFS      12'h008
`define LNBOCF_MASK_OFS     12'h00c
`define LNBOCF_ADDR_OFS     12'h010

// ==========================================================
// control register fields
`define LNBOCF_CTRL_BOOST   0
`define LNBOCF_CTRL_ENABLE  1
`define LNBOCF_CTRL_RESET   2'h0

// ==========================================================
// status register fields
`define LNBOCF_ST_FAULT     0
`define LNBOCF_ST_OVERCUR   1
`define LNBOCF_ST_RAISED    2
`define LNBOCF_ST_SKIP      3
`define LNBOCF_ST_STRONG    4
`define LNBOCF_ST_OUTON     5

// ==========================================================
// interrupt event bits
`define LNBOCF_EV_FAULT     0
`define LNBOCF_EV_WINDOW    1
`define LNBOCF_EV_W         2

// ==========================================================
// timing
`define LNBOCF_CLK_HZ       50000000
`define LNBOCF_DIS_TIME_MS  45
`define LNBOCF_DIS_CYCLES   ((`LNBOCF_CLK_HZ / 1000) * `LNBOCF_DIS_TIME_MS)

// ==========================================================
// serial address base, low two bits from the select pin level
`define LNBOCF_BUS_ADDR_BASE 7'h08

`endif

// ==== src/lnbocf_top.v ====
/*
  overcurrent supervision of the coax output supply: fault timer,
  one-shot raised limit, pull-down strength, pulse skip hysteresis,
  serial address pick, apb registers and interrupt.
  assumes analog comparators and pin levels arrive asynchronously and
  are synchronised here; one clock, core_clk at 50 MHz.
*/
`timescale 1ns/1ps
`include "lnbocf_regs.vh"

module lnbocf_top #(
  parameter DIS_CYCLES = `LNBOCF_DIS_CYCLES
) (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        at_limit,
  input  wire        above_skip_high,
  input  wire        below_skip_low,
  input  wire        tone_gate_input,
  input  wire [1:0]  addr_select_level,
  output reg         output_on,
  output reg         raised_limit,
  output reg         strong_pulldown,
  output reg         pulse_skip,
  output reg         overcurrent_fault_flag,
  output reg  [6:0]  bus_address,
  output reg         irq
);

  // ==========================================================
  // input synchronisers
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  wire [5:0] raw_in = {addr_select_level, tone_gate_input,
                       below_skip_low, above_skip_high, at_limit};

  // pins are asynchronous; only the second stage is read
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire lim_s  = sync2_reg[0];
  wire hi_s   = sync2_reg[1];
  wire lo_s   = sync2_reg[2];
  wire tone_s = sync2_reg[3];
  wire [1:0] sel_s = sync2_reg[5:4];

  // ==========================================================
  // apb decode
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_ctrl = wr_acc & hit(paddr, `LNBOCF_CTRL_OFS);
  wire wr_mask = wr_acc & hit(paddr, `LNBOCF_MASK_OFS);
  wire rd_irq  = rd_acc & hit(paddr, `LNBOCF_IRQ_OFS);
  wire mapped  = hit(paddr, `LNBOCF_CTRL_OFS) |
                 hit(paddr, `LNBOCF_STAT_OFS) |
                 hit(paddr, `LNBOCF_IRQ_OFS)  |
                 hit(paddr, `LNBOCF_MASK_OFS) |
                 hit(paddr, `LNBOCF_ADDR_OFS);

  // ==========================================================
  // overcurrent state machine, one-hot
  localparam ST_OFF   = 4'h1;
  localparam ST_RUN   = 4'h2;
  localparam ST_TIMED = 4'h4;
  localparam ST_FAULT = 4'h8;

  localparam [31:0] QUARTER = DIS_CYCLES / 4;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [31:0] timer_reg;
  reg [31:0] timer_next;
  reg        arm_reg;
  reg        arm_next;
  reg        en_reg;
  reg        en_next;
  reg        raised_next;
  reg        fault_ev;
  reg        window_ev;

  always @* begin
    state_next  = state_reg;
    timer_next  = timer_reg;
    arm_next    = arm_reg;
    en_next     = en_reg;
    raised_next = raised_limit;
    fault_ev    = 1'b0;
    window_ev   = 1'b0;
    // host write of the control word: arm and enable
    if (wr_ctrl) begin
      arm_next = pwdata[`LNBOCF_CTRL_BOOST];
      en_next  = pwdata[`LNBOCF_CTRL_ENABLE];
    end
    case (state_reg)
      ST_OFF: begin
        raised_next = 1'b0;
        if (en_next)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        timer_next = 32'h0;
        if (!en_next) begin
          state_next = ST_OFF;
        end else if (lim_s) begin
          state_next  = ST_TIMED;
          timer_next  = 32'h1;
          raised_next = arm_reg;
        end
      end
      ST_TIMED: begin
        timer_next = timer_reg + 32'h1;
        if (!en_next) begin
          state_next  = ST_OFF;
          raised_next = 1'b0;
        end else if (!lim_s) begin
          state_next  = ST_RUN;
          timer_next  = 32'h0;
          raised_next = 1'b0;
        end else if (timer_reg >= DIS_CYCLES) begin
          state_next  = ST_FAULT;
          raised_next = 1'b0;
          en_next     = 1'b0;
          fault_ev    = 1'b1;
        end
        // quarter window over: back to set limit, disarm
        if (raised_limit && timer_reg >= QUARTER) begin
          raised_next = 1'b0;
          arm_next    = 1'b0;
          window_ev   = 1'b1;
        end
      end
      ST_FAULT: begin
        timer_next = 32'h0;
        // stays off until the host writes enable again
        if (wr_ctrl && pwdata[`LNBOCF_CTRL_ENABLE])
          state_next = ST_RUN;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // ==========================================================
  // interrupt status, mask
  reg [`LNBOCF_EV_W-1:0] irq_st_reg;
  reg [`LNBOCF_EV_W-1:0] mask_reg;
  wire [`LNBOCF_EV_W-1:0] ev = {window_ev, fault_ev};
  // a read clears only the bits the host was shown; an event landing
  // after the data was latched, or in the read cycle itself, survives
  wire [`LNBOCF_EV_W-1:0] irq_st_next =
    (rd_irq ? (irq_st_reg & ~prdata[`LNBOCF_EV_W-1:0]) : irq_st_reg) | ev;

  // ==========================================================
  // fault flag: sticky until host re-enables; new fault wins
  wire fault_next = fault_ev |
    (overcurrent_fault_flag &
     ~(wr_ctrl & pwdata[`LNBOCF_CTRL_ENABLE]));

  // ==========================================================
  // pulse skip hysteresis
  wire skip_next = hi_s ? 1'b1 : (lo_s ? 1'b0 : pulse_skip);

  // ==========================================================
  // read mux
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0;
    if (hit(paddr, `LNBOCF_CTRL_OFS))
      rd_next = {30'h0, en_reg, arm_reg};
    else if (hit(paddr, `LNBOCF_STAT_OFS))
      rd_next = {26'h0, output_on, strong_pulldown, pulse_skip,
                 raised_limit, state_reg == ST_TIMED,
                 overcurrent_fault_flag};
    else if (hit(paddr, `LNBOCF_IRQ_OFS))
      rd_next = {30'h0, irq_st_reg};
    else if (hit(paddr, `LNBOCF_MASK_OFS))
      rd_next = {30'h0, mask_reg};
    else if (hit(paddr, `LNBOCF_ADDR_OFS))
      rd_next = {25'h0, bus_address};
  end

  // ==========================================================
  // state registers
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg              <= ST_OFF;
      timer_reg              <= 32'h0;
      arm_reg                <= 1'b0;
      en_reg                 <= 1'b0;
      raised_limit           <= 1'b0;
      output_on              <= 1'b0;
      overcurrent_fault_flag <= 1'b0;
      strong_pulldown        <= 1'b0;
      pulse_skip             <= 1'b0;
      bus_address            <= `LNBOCF_BUS_ADDR_BASE;
      irq_st_reg             <= 2'h0;
      mask_reg               <= 2'h0;
      irq                    <= 1'b0;
    end else begin
      state_reg              <= state_next;
      timer_reg              <= timer_next;
      arm_reg                <= arm_next;
      en_reg                 <= en_next;
      raised_limit           <= raised_next;
      output_on              <= state_next[1] | state_next[2];
      overcurrent_fault_flag <= fault_next;
      strong_pulldown        <= tone_s;
      pulse_skip             <= skip_next;
      bus_address            <= `LNBOCF_BUS_ADDR_BASE | {5'h0, sel_s};
      irq_st_reg             <= irq_st_next;
      if (wr_mask)
        mask_reg <= pwdata[`LNBOCF_EV_W-1:0];
      irq                    <= |(irq_st_next & mask_reg);
    end
  end

  // ==========================================================
  // apb answer: no wait state, ready in the first access cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0;
    end
  end

endmodule

// ==== testbench/lnbocf_lnb_model.sv ====
/* converter on the coax, seen through its effect on the comparators
   assumes the bench commands shorts and boost load bands */
`timescale 1ns/1ps
// ==========================================
// converter model
module lnbocf_lnb_model (
  input  wire       core_clk,
  input  wire       output_on,
  input  wire       short_req,
  input  wire [1:0] boost_band,
  output reg        at_limit,
  output reg        above_skip_high,
  output reg        below_skip_low
);
  // no supply, no current: a short only loads a live output
  always @(posedge core_clk) begin
    at_limit        <= short_req && output_on;
    above_skip_high <= (boost_band == 2'h2);
    below_skip_low  <= (boost_band == 2'h0);
  end
endmodule

// ==== testbench/lnbocf_top_chk.sv ====
/* assertions on the lnbocf_top ports
   assumes one clock domain, attached by the bind below */
`timescale 1ns/1ps
// ==========================================
// port checker
module lnbocf_chk #(
  parameter DIS_CYCLES = 40
) (
  input wire       core_clk,
  input wire       resetn,
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire       at_limit,
  input wire       above_skip_high,
  input wire       below_skip_low,
  input wire       tone_gate_input,
  input wire [1:0] addr_select_level,
  input wire       output_on,
  input wire       raised_limit,
  input wire       strong_pulldown,
  input wire       pulse_skip,
  input wire       overcurrent_fault_flag,
  input wire [6:0] bus_address
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  int ot_cnt;
  int rl_cnt;
  reg wr_q;
  // run lengths; counters instead of long repetitions
  always @(posedge core_clk or negedge resetn)
    if (!resetn) begin
      ot_cnt <= 0;
      rl_cnt <= 0;
      wr_q   <= 1'b0;
    end else begin
      ot_cnt <= (at_limit && output_on) ? ot_cnt + 1 : 0;
      rl_cnt <= raised_limit ? rl_cnt + 1 : 0;
      wr_q   <= psel && penable && pwrite;
    end
  sequence s_tone_hi; tone_gate_input[*4]; endsequence
  sequence s_tone_lo; !tone_gate_input[*4]; endsequence
  chk_pd_strong: assert property (s_tone_hi |=> strong_pulldown)
    else $error("strong pulldown missing");
  chk_pd_weak: assert property (s_tone_lo |=> !strong_pulldown)
    else $error("weak pulldown missing");
  chk_skip_on: assert property (above_skip_high[*4] |=> pulse_skip)
    else $error("skip not entered");
  chk_skip_off: assert property (
    (below_skip_low && !above_skip_high)[*4] |=> !pulse_skip)
    else $error("skip not left");
  chk_addr_pick: assert property ($stable(addr_select_level)[*4]
    |-> bus_address == {5'h02, addr_select_level})
    else $error("bus address wrong");
  chk_fault_early: assert property ($rose(overcurrent_fault_flag)
    |-> !output_on && ot_cnt >= DIS_CYCLES)
    else $error("fault before disable time");
  chk_fault_late: assert property (ot_cnt < DIS_CYCLES + 8)
    else $error("fault missing after disable time");
  chk_no_restart: assert property ($rose(output_on)
    |-> wr_q || $past(wr_q))
    else $error("output restarted without write");
  chk_raise_len: assert property ($fell(raised_limit) && output_on
    |-> rl_cnt == DIS_CYCLES / 4)
    else $error("raised window length wrong");
endmodule
bind lnbocf_top lnbocf_chk #(.DIS_CYCLES(DIS_CYCLES)) lnbocf_chk_inst (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .at_limit(at_limit), .above_skip_high(above_skip_high),
  .below_skip_low(below_skip_low), .tone_gate_input(tone_gate_input),
  .addr_select_level(addr_select_level), .output_on(output_on),
  .raised_limit(raised_limit), .strong_pulldown(strong_pulldown),
  .pulse_skip(pulse_skip), .overcurrent_fault_flag(overcurrent_fault_flag),
  .bus_address(bus_address));

// ==== testbench/lnbocf_top_test.sv ====
/* self-checking bench for lnbocf_top with the converter model
   assumes the disable time shortened to DIS cycles */
`timescale 1ns/1ps
`include "lnbocf_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module lnbocf_top_test;
  localparam DIS = 40;
  reg         core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg         pwrite = 1'b0, tone = 1'b0, short_req = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [1:0]  lvl = 2'h0, band = 2'h1;
  wire [31:0] prdata;
  wire        pready, pslverr, at_lim, ash, bsl, on, rl, spd, skip, flt, irq;
  wire [6:0]  baddr;
  int         error_cnt = 0, samples_checked = 0, i, n;
  // ==========================================
  // design and converter
  lnbocf_top #(.DIS_CYCLES(DIS)) lnbocf_top_inst (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .at_limit(at_lim),
    .above_skip_high(ash), .below_skip_low(bsl), .tone_gate_input(tone),
    .addr_select_level(lvl), .output_on(on), .raised_limit(rl),
    .strong_pulldown(spd), .pulse_skip(skip),
    .overcurrent_fault_flag(flt), .bus_address(baddr), .irq(irq));
  lnbocf_lnb_model lnbocf_lnb_model_inst (
    .core_clk(core_clk), .output_on(on), .short_req(short_req),
    .boost_band(band), .at_limit(at_lim), .above_skip_high(ash),
    .below_skip_low(bsl));
  initial forever #10 core_clk = ~core_clk;
  function [6:0] exp_addr(input [1:0] l);
    exp_addr = 7'h08 + l;
  endfunction
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one apb transfer; an edge first so strobes never change twice
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // short held past the disable time, raised cycles counted
  task short_run;
    n = 0;
    short_req <= 1'b1;
    repeat (DIS + 10) begin
      @(posedge core_clk);
      if (rl === 1'b1)
        n++;
    end
    short_req <= 1'b0;
    cyc(2);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #60000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h5a82824d));
    cyc(20);
    resetn <= 1'b1;
    apb(1'b0, `LNBOCF_CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    for (i = 0; i < 4; i++) begin
      lvl  <= i[1:0];
      tone <= 1'($urandom);
      cyc(4);
      `CHK("bus address", exp_addr(i[1:0]), baddr)
      `CHK("pulldown", tone, spd)
    end
    apb(1'b0, `LNBOCF_ADDR_OFS, 32'h0);
    `CHK("addr reg", {25'h0, exp_addr(lvl)}, rd)
    // above, in band, below, in band: the band keeps the last state
    for (i = 0; i < 4; i++) begin
      band <= (i == 0) ? 2'h2 : (i == 2) ? 2'h0 : 2'h1;
      // model register plus two sync stages plus the skip flop
      cyc(5);
      `CHK("pulse skip", (i < 2), skip)
    end
    $display("test pins done");
    apb(1'b1, `LNBOCF_MASK_OFS, 32'h3);
    apb(1'b1, `LNBOCF_CTRL_OFS, 32'h2);
    for (i = 0; i < 3; i++) begin
      short_req <= 1'b1;
      cyc($urandom_range(DIS - 4, DIS / 2));
      short_req <= 1'b0;
      cyc(4);
    end
    `CHK("fault flag", 1'b0, flt)
    short_run;
    `CHK("raised cycles", 0, n)
    `CHK("fault flag", 1'b1, flt)
    `CHK("irq", 1'b1, irq)
    cyc(8);
    `CHK("output on", 1'b0, on)
    apb(1'b0, `LNBOCF_STAT_OFS, 32'h0);
    `CHK("status", {26'h0, 1'b0, tone, 4'h1}, rd)
    apb(1'b0, `LNBOCF_IRQ_OFS, 32'h0);
    `CHK("irq status", 1'b1, rd[0])
    cyc(2);
    `CHK("irq", 1'b0, irq)
    $display("test fault done");
    // retry spacing after a shutdown, scaled like the disable time
    cyc(DIS * 10);
    // host re-arms and re-enables; fault event masked this time
    apb(1'b1, `LNBOCF_MASK_OFS, 32'h0);
    apb(1'b1, `LNBOCF_CTRL_OFS, 32'h3);
    cyc(1);
    `CHK("fault flag", 1'b0, flt)
    `CHK("output on", 1'b1, on)
    short_run;
    `CHK("raised cycles", DIS / 4, n)
    `CHK("fault flag", 1'b1, flt)
    `CHK("irq", 1'b0, irq)
    apb(1'b0, `LNBOCF_CTRL_OFS, 32'h0);
    `CHK("arm bit", 1'b0, rd[0])
    apb(1'b0, `LNBOCF_IRQ_OFS, 32'h0);
    `CHK("irq status", 2'h3, rd[1:0])
    $display("test raised limit done");
    end_of_test;
  end
endmodule
